// ===== src/stepper_pkg.sv
`default_nettype none
package stepper_pkg;
  // system clock
  localparam int MCLK_PERIOD_NS = 8;
  localparam int CYC_PER_US = 1000 / MCLK_PERIOD_NS;
  // least hold time of the hard clear pin, rounded up to whole cycles
  localparam int CLEAR_PULSE_MIN_NS = 100;
  localparam int CLEAR_PULSE_CYC =
    (CLEAR_PULSE_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  // watchdog timing: one timeout_select step, early window, reset pulse
  localparam int TIMEOUT_STEP_US = 1000;
  localparam int EARLY_WINDOW_US = 100;
  localparam int RESET_PULSE_US = 100;
  // command byte
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h4;
  // register map
  localparam int NUM_CR = 4;
  localparam int NUM_SR = 4;
  localparam int SR_BITS = 7;
  localparam logic [4:0] ADDR_CRWD = 5'h00;
  localparam logic [4:0] ADDR_CR2 = 5'h03;
  localparam logic [4:0] ADDR_SR0 = 5'h04;
  // field positions
  localparam int WDEN_BIT = 7;
  localparam int WDT_LSB = 3;
  localparam int MOTEN_BIT = 7;
  localparam int SLEEP_BIT = 6;
  localparam int BOOT_BIT = 6;
  // frame counting
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [4:0] WRITE_LEN = 5'h10;
  localparam logic [4:0] TOT_MAX = 5'h1f;
  // synchronised pin positions and their idle levels
  localparam int PIN_SCLK = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_DIN = 2;
  localparam int PIN_CLR = 3;
  localparam int PIN_STEP = 4;
  localparam int PIN_ROT = 5;
  localparam int NUM_PINS = 6;
  localparam logic [NUM_PINS-1:0] PIN_INIT = 6'h02;
  typedef enum logic {FR_CMD, FR_DATA} frame_t;
endpackage
`default_nettype wire

// ===== src/wd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wd_if;
  logic enable;
  logic kick;
  logic clear;
  logic run;
  logic [3:0] timeout_select;
  logic fire;
  logic rst_n;
  logic rst_oe;
  modport ctrl(output enable, kick, clear, run, timeout_select,
               input fire, rst_n, rst_oe);
  modport dog(input enable, kick, clear, run, timeout_select,
              output fire, rst_n, rst_oe);
endinterface
`default_nettype wire

// ===== src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t st_q, st_d;

  // two stages; only the second stage is visible outside
  always_comb begin
    st_d = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= {INIT, INIT};
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule
`default_nettype wire

// ===== src/watchdog_timer.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer import stepper_pkg::*; #(
  parameter int STEP_CYC = TIMEOUT_STEP_US * CYC_PER_US,
  parameter int EARLY_CYC = EARLY_WINDOW_US * CYC_PER_US,
  parameter int PULSE_CYC = RESET_PULSE_US * CYC_PER_US,
  parameter int CNT_W = 24
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  wd_if.dog bus
);
  typedef struct packed {
    logic running;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] rst_cnt;
    logic fire;
    logic rst_n;
    logic rst_oe;
  } wd_t;
  wd_t st_q, st_d;
  logic [CNT_W-1:0] limit;

  if (CNT_W < 2 || 64'(16 * STEP_CYC) >= (64'd1 << CNT_W) ||
      EARLY_CYC >= STEP_CYC || PULSE_CYC < 1) begin : g_chk
    $error("watchdog_timer: counter too narrow or timing inconsistent");
  end

  // timeout grows in whole steps with the select field
  assign limit = CNT_W'((32'(bus.timeout_select) + 32'd1) * 32'(STEP_CYC));

  always_comb begin
    st_d = st_q;
    st_d.fire = 1'b0;
    if (st_q.rst_cnt != '0) begin
      st_d.rst_cnt = st_q.rst_cnt - CNT_W'(1);
    end
    if (bus.clear || !bus.enable) begin
      st_d.running = 1'b0;
      st_d.cnt = '0;
    end else if (bus.kick && !st_q.running) begin
      st_d.running = 1'b1; // first enable starts the timer
      st_d.cnt = '0;
    end else if (st_q.running) begin
      // early rewrite or missing rewrite both reset the host (see R2)
      if ((bus.kick && st_q.cnt < CNT_W'(EARLY_CYC)) ||
          (!bus.kick && bus.run && st_q.cnt >= limit)) begin
        st_d.fire = 1'b1;
        st_d.cnt = '0;
        st_d.rst_cnt = CNT_W'(PULSE_CYC);
      end else if (bus.kick) begin
        st_d.cnt = '0; // timely rewrite restarts the timer (see R1)
      end else if (bus.run) begin
        st_d.cnt = st_q.cnt + CNT_W'(1);
      end
    end
    // hard clear stops everything and never pulls the host reset (see R6)
    if (bus.clear) begin
      st_d.rst_cnt = '0;
      st_d.fire = 1'b0;
    end
    st_d.rst_n = (st_d.rst_cnt == '0);
    st_d.rst_oe = (st_d.rst_cnt != '0);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{running: 1'b0, cnt: '0, rst_cnt: '0, fire: 1'b0,
                rst_n: 1'b1, rst_oe: 1'b0};
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign bus.fire = st_q.fire;
  assign bus.rst_n = st_q.rst_n;
  assign bus.rst_oe = st_q.rst_oe;

  default clocking wcb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  timeout_fire_a: assert property ( // see R2
    clk_en && st_q.running && bus.enable && !bus.clear && !bus.kick &&
    bus.run && st_q.cnt >= limit |=> st_q.fire ##1 !st_q.rst_n)
    else $error("watchdog did not fire at timeout");
  early_kick_a: assert property ( // see R2
    clk_en && st_q.running && bus.enable && !bus.clear && bus.kick &&
    st_q.cnt < CNT_W'(EARLY_CYC) |=> st_q.fire)
    else $error("early rewrite did not fire watchdog");
  clear_quiet_a: assert property ( // see R6
    clk_en && bus.clear |=> st_q.rst_n && !st_q.running && !st_q.fire)
    else $error("hard clear left watchdog active");
endmodule
`default_nettype wire

// ===== src/stepper_spi_slave_watchdog_sleep.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) host rewrites enable bit before timeout
// (R2) early or late rewrite pulls host reset
// (R3) readable boot flag marks watchdog reset
// (R4) four-bit select field sets timeout length
// (R5) held hard clear resets registers unless sleeping
// (R6) hard clear resets watchdog, no host reset
// (R7) sleep: drivers off, inputs ignored, clocks quiet
// (R8) host waits pump start-up after sleep exit
// (R9) device is slave only, never initiates
// (R10) mode 0: sample rising, shift falling
// (R11) serial output released while select high
// (R12) bytes msb first, packet within select low
// (R13) first byte: three-bit opcode, five-bit index
// (R14) eighth falling edge loads addressed register
// (R15) status bytes carry odd-ones parity in D7
// (R16) host rereads status on parity error
// (R17) status read clears; updates only select high
// (R18) host raises select after status read
// (R19) write stored at first clock select high
// (R20) write packet not sixteen bits is discarded
// (R21) writes to read-only registers are ignored
// (R22) each byte returns last addressed register
// (R23) writing enable zero stops watchdog, clears flag
// (R24) control registers read/write, reset to zero
// (R25) select high restarts bit count and frame
// (R26) latched error holds fault low until read
module stepper_spi_slave_watchdog_sleep import stepper_pkg::*; #(
  parameter int TIMEOUT_STEP_CYC = TIMEOUT_STEP_US * CYC_PER_US,
  parameter int EARLY_WINDOW_CYC = EARLY_WINDOW_US * CYC_PER_US,
  parameter int RESET_PULSE_CYC = RESET_PULSE_US * CYC_PER_US,
  parameter int CLEAR_CYC = CLEAR_PULSE_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic hard_clear_pin,
  input wire logic step_pulse,
  input wire logic rot_sense,
  input wire logic [NUM_SR-1:0][SR_BITS-1:0] status_events,
  output logic reset_out_n,
  output logic reset_out_oe,
  output logic fault_n,
  output logic fault_oe,
  output logic step_out,
  output logic rot_sense_out,
  output logic drivers_hiz,
  output logic clocks_run,
  output logic [NUM_CR-1:0][7:0] ctrl_regs
);
  localparam int CLR_W = $clog2(CLEAR_CYC + 1);

  if (CLEAR_CYC < 1 || NUM_CR != 4 || NUM_SR != 4) begin : g_chk
    $error("stepper spi: unsupported register count or clear time");
  end

  typedef struct packed {
    logic sclk_q;
    logic cs_q;
    logic [2:0] bit_cnt;
    logic [4:0] tot;
    frame_t frame;
    logic [4:0] addr;
    logic [6:0] rx;
    logic [7:0] tx;
    logic wr_ok;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic [NUM_CR-1:0][7:0] cr;
    logic [NUM_SR-1:0][SR_BITS-1:0] lat;
    logic [NUM_SR-1:0] clr_pend;
    logic boot;
    logic kick;
    logic [CLR_W-1:0] clr_cnt;
    logic hclr;
    logic so;
    logic so_oe;
    logic flt_n;
    logic flt_oe;
    logic step_o;
    logic rot_o;
    logic hiz;
    logic run;
  } st_t;
  st_t st_q, st_d;

  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_s;
  logic sclk_s;
  logic cs_s;
  logic din_s;
  logic clr_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic sleep;
  logic commit;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;
  logic [SR_BITS-1:0] sr_val;

  wd_if wd_bus();

  // status registers sit directly after the control registers
  function automatic logic is_status(input logic [4:0] a);
    return (a >= ADDR_SR0) && (a < ADDR_SR0 + 5'(NUM_SR));
  endfunction

  function automatic logic is_ctrl(input logic [4:0] a);
    return a < ADDR_CRWD + 5'(NUM_CR);
  endfunction

  function automatic logic [1:0] sr_idx(input logic [4:0] a);
    return 2'(a - ADDR_SR0);
  endfunction

  function automatic logic [1:0] cr_idx(input logic [4:0] a);
    return 2'(a - ADDR_CRWD);
  endfunction

  // every pin crosses into mclk through two flops
  assign pin_raw[PIN_SCLK] = spi_sclk;
  assign pin_raw[PIN_CS] = spi_cs_n;
  assign pin_raw[PIN_DIN] = serial_in;
  assign pin_raw[PIN_CLR] = hard_clear_pin;
  assign pin_raw[PIN_STEP] = step_pulse;
  assign pin_raw[PIN_ROT] = rot_sense;

  pin_sync #(
    .W(NUM_PINS),
    .INIT(PIN_INIT)
  ) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .d(pin_raw),
    .q(pin_s)
  );

  watchdog_timer #(
    .STEP_CYC(TIMEOUT_STEP_CYC),
    .EARLY_CYC(EARLY_WINDOW_CYC),
    .PULSE_CYC(RESET_PULSE_CYC),
    .CNT_W(24)
  ) u_wd (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .bus(wd_bus.dog)
  );

  // edge finding on the synchronised link clock and select
  assign sclk_s = pin_s[PIN_SCLK];
  assign cs_s = pin_s[PIN_CS];
  assign din_s = pin_s[PIN_DIN];
  assign clr_s = pin_s[PIN_CLR];
  assign sclk_rise = sclk_s & ~st_q.sclk_q; // see R10
  assign sclk_fall = ~sclk_s & st_q.sclk_q;
  assign cs_rise = cs_s & ~st_q.cs_q;
  assign sleep = st_q.cr[cr_idx(ADDR_CR2)][SLEEP_BIT];
  assign byte_in = {st_q.rx, din_s}; // see R12
  // only a complete 16-bit write to a control register lands
  assign commit = cs_rise && st_q.wr_ok && st_q.tot == WRITE_LEN &&
                  is_ctrl(st_q.wr_addr); // see R20 see R21

  // watchdog enable and timeout select come straight from the control word; kick, clear and run are flops here
  assign wd_bus.enable = st_q.cr[cr_idx(ADDR_CRWD)][WDEN_BIT];
  assign wd_bus.timeout_select =
    st_q.cr[cr_idx(ADDR_CRWD)][WDT_LSB +: 4]; // see R4
  assign wd_bus.kick = st_q.kick;
  assign wd_bus.clear = st_q.hclr;
  assign wd_bus.run = st_q.run;

  // read data for the addressed register; status gets parity in D7
  always_comb begin
    sr_val = st_q.lat[sr_idx(st_q.addr)];
    rd_byte = 8'h00;
    if (is_ctrl(st_q.addr)) begin
      rd_byte = st_q.cr[cr_idx(st_q.addr)]; // see R24
    end else if (is_status(st_q.addr)) begin
      if (st_q.addr == ADDR_SR0) begin
        sr_val[BOOT_BIT] = sr_val[BOOT_BIT] | st_q.boot; // see R3
      end
      rd_byte = {^sr_val, sr_val}; // see R15
    end
  end

  // serial engine, write commit, status latching, hard clear, sleep
  always_comb begin
    st_d = st_q;
    st_d.sclk_q = sclk_s;
    st_d.cs_q = cs_s;
    st_d.kick = 1'b0;
    if (cs_s) begin
      // a new select low always starts a fresh packet
      st_d.bit_cnt = 3'h0; // see R25
      st_d.tot = 5'h00;
      st_d.frame = FR_CMD;
      st_d.wr_ok = 1'b0;
    end else begin
      // the device only reacts to host clock edges (see R9)
      if (sclk_rise) begin
        st_d.rx = byte_in[6:0];
        st_d.bit_cnt = st_q.bit_cnt + 3'h1;
        if (st_q.tot != TOT_MAX) begin
          st_d.tot = st_q.tot + 5'h01;
        end
        if (st_q.bit_cnt == LAST_BIT) begin
          if (st_q.frame == FR_DATA) begin
            st_d.wr_data = byte_in;
            st_d.wr_ok = 1'b1;
            st_d.frame = FR_CMD;
          end else begin
            st_d.addr = byte_in[4:0]; // see R13 see R22
            if (byte_in[7:5] == OP_WRITE) begin
              st_d.frame = FR_DATA;
              st_d.wr_addr = byte_in[4:0];
            end else if (byte_in[7:5] == OP_READ &&
                         is_status(byte_in[4:0])) begin
              // clear is applied once select goes high again
              st_d.clr_pend[sr_idx(byte_in[4:0])] = 1'b1; // see R17
            end
          end
        end
      end
      if (sclk_fall) begin
        if (st_q.bit_cnt == 3'h0 && st_q.tot != 5'h00) begin
          st_d.tx = rd_byte; // see R14 see R22
        end else begin
          st_d.tx = {st_q.tx[6:0], 1'b0};
        end
      end
    end
    // write lands at the first mclk edge with select high
    if (commit) begin
      st_d.cr[cr_idx(st_q.wr_addr)] = st_q.wr_data; // see R19
      if (st_q.wr_addr == ADDR_CRWD) begin
        if (st_q.wr_data[WDEN_BIT]) begin
          st_d.kick = 1'b1; // see R1
        end else begin
          st_d.boot = 1'b0; // see R23
        end
      end
    end
    // a firing watchdog wins over an enable-zero clear in the same cycle
    if (wd_bus.fire) begin
      st_d.boot = 1'b1; // see R3
    end
    // oscillator runs while awake or while the host is talking
    st_d.run = ~sleep | ~cs_s; // see R7
    // status and fault only move while select is high and awake, or on a hard clear
    if (cs_s && st_d.run) begin
      for (int i = 0; i < NUM_SR; i++) begin
        st_d.lat[i] = status_events[i] |
          (st_q.lat[i] & ~{SR_BITS{st_q.clr_pend[i]}}); // see R17
      end
      st_d.clr_pend = '0;
      st_d.flt_oe = |st_d.lat; // see R26
      st_d.flt_n = ~(|st_d.lat);
    end
    // hard clear must be held long enough, and is ignored in sleep
    if (clr_s && !sleep) begin
      if (st_q.clr_cnt != CLR_W'(CLEAR_CYC)) begin
        st_d.clr_cnt = st_q.clr_cnt + CLR_W'(1);
      end else begin
        st_d.hclr = 1'b1; // see R5
      end
    end else begin
      st_d.clr_cnt = '0;
      st_d.hclr = 1'b0;
    end
    if (st_q.hclr) begin
      st_d.cr = '0; // see R24
      st_d.lat = '0;
      st_d.clr_pend = '0;
      st_d.boot = 1'b0;
      st_d.wr_ok = 1'b0;
      st_d.kick = 1'b0;
      st_d.flt_oe = 1'b0;
      st_d.flt_n = 1'b1;
    end
    // pins seen by the motor side; step forced low and sense frozen in sleep
    st_d.hiz = st_d.cr[cr_idx(ADDR_CR2)][SLEEP_BIT] |
               ~st_d.cr[cr_idx(ADDR_CR2)][MOTEN_BIT]; // see R7
    st_d.step_o = pin_s[PIN_STEP] & ~sleep;
    if (!sleep) begin
      st_d.rot_o = pin_s[PIN_ROT];
    end
    // serial output shows the top bit, released when deselected
    st_d.so = st_d.tx[7];
    st_d.so_oe = ~cs_s; // see R11
  end

  // reset value is a constant; the whole state moves only on clk_en
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{sclk_q: 1'b0, cs_q: 1'b1, bit_cnt: 3'h0, tot: 5'h00,
                frame: FR_CMD, addr: 5'h00, rx: 7'h00, tx: 8'h00,
                wr_ok: 1'b0, wr_addr: 5'h00, wr_data: 8'h00,
                cr: '0, lat: '0, clr_pend: '0, boot: 1'b0,
                kick: 1'b0, clr_cnt: '0, hclr: 1'b0, so: 1'b0,
                so_oe: 1'b0, flt_n: 1'b1, flt_oe: 1'b0,
                step_o: 1'b0, rot_o: 1'b0, hiz: 1'b1, run: 1'b1};
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // all outputs are flops of this module or the watchdog
  assign serial_out = st_q.so;
  assign serial_out_oe = st_q.so_oe;
  assign reset_out_n = wd_bus.rst_n;
  assign reset_out_oe = wd_bus.rst_oe;
  assign fault_n = st_q.flt_n;
  assign fault_oe = st_q.flt_oe;
  assign step_out = st_q.step_o;
  assign rot_sense_out = st_q.rot_o;
  assign drivers_hiz = st_q.hiz;
  assign clocks_run = st_q.run;
  assign ctrl_regs = st_q.cr;

  default clocking mcb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence byte_end_s;
    clk_en && sclk_fall && !cs_s && st_q.bit_cnt == 3'h0 &&
    st_q.tot != 5'h00;
  endsequence

  do_release_a: assert property ( // see R11
    clk_en && cs_s |=> !serial_out_oe)
    else $error("serial output driven while deselected");
  frame_reset_a: assert property ( // see R25
    clk_en && cs_s |=> st_q.bit_cnt == 3'h0 && st_q.tot == 5'h00)
    else $error("frame state not reset while deselected");
  short_write_a: assert property ( // see R20
    clk_en && cs_rise && st_q.tot != WRITE_LEN && !st_q.hclr |=>
    $stable(st_q.cr))
    else $error("write of wrong length changed a register");
  ro_write_a: assert property ( // see R21
    clk_en && cs_rise && is_status(st_q.wr_addr) && !st_q.hclr |=>
    $stable(st_q.cr))
    else $error("write to status changed a control register");
  commit_a: assert property ( // see R19
    clk_en && commit && !st_q.hclr |=>
    st_q.cr[$past(cr_idx(st_q.wr_addr))] == $past(st_q.wr_data))
    else $error("write data not stored on select rise");
  tx_load_a: assert property ( // see R14
    byte_end_s |=> st_q.tx == $past(rd_byte) ##1 serial_out == st_q.tx[7])
    else $error("output shift register not loaded at byte end");
  parity_ok_a: assert property ( // see R15
    is_status(st_q.addr) |-> (^rd_byte) == 1'b0)
    else $error("status byte parity wrong");
  status_hold_a: assert property ( // see R17
    clk_en && !cs_s && !st_q.hclr |=> $stable(st_q.lat) && $stable(fault_n))
    else $error("status moved while selected");
  // a wake-up write may clear the sleep bit in the very next cycle, so the
  // driver state is checked in the same cycle and the step gate one later
  sleep_off_a: assert property ( // see R7
    clk_en && sleep && !st_q.hclr |-> drivers_hiz ##1 !step_out)
    else $error("drivers or steps active in sleep");
  clear_fire_a: assert property ( // see R5
    clk_en && clr_s && !sleep && st_q.clr_cnt == CLR_W'(CLEAR_CYC) |=>
    st_q.hclr ##1 (!clk_en || st_q.cr == '0))
    else $error("held hard clear did not clear registers");
endmodule
`default_nettype wire

// ===== testbench/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the serial link; it alone opens a packet
module spi_host_model (
  input wire logic mclk,
  input wire logic miso,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  logic [23:0] rx_q[$];
  // select high and clock low while idle
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // n bits msb first in one select-low period
  task automatic xfer(input logic [23:0] tx, input int n, input bit keep);
    logic [23:0] rx;
    rx = 24'h00_0000;
    @(negedge mclk);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = tx[i];
      repeat (10) @(negedge mclk);
      sclk = 1'b1; // mode 0: sample on the rise
      rx = {rx[22:0], miso};
      repeat (10) @(negedge mclk);
      sclk = 1'b0;
    end
    repeat (10) @(negedge mclk);
    cs_n = 1'b1;
    mosi = ~mosi; // no pull-up on this line, so no stale level
    if (keep) begin
      rx_q.push_back(rx);
    end
    repeat (10) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// ===== testbench/stepper_spi_slave_watchdog_sleep_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); \
  end \
end
module stepper_spi_slave_watchdog_sleep_tb_top import stepper_pkg::*;;
  logic mclk, reset_n, sclk, cs_n, mosi, miso, so, so_oe, hclr, step, rot;
  logic rst_out_n, fault, step_out, hiz, crun, rso, roe, foe;
  logic [NUM_SR-1:0][SR_BITS-1:0] ev;
  logic [NUM_CR-1:0][7:0] cr, exp_c;
  logic [7:0] exp_q[$];
  logic [7:0] d, eb;
  logic [6:0] v;
  logic [23:0] got;
  logic [31:0] seed = 32'h0000_0062;
  logic [31:0] r;
  int fails = 0;
  int total_checks = 0;
  int fires = 0;
  // released data-out line is pulled up
  assign miso = so_oe ? so : 1'b1;
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  spi_host_model H (.mclk(mclk), .miso(miso), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi));
  // short counts keep the watchdog run small; early stays below step
  stepper_spi_slave_watchdog_sleep #(.TIMEOUT_STEP_CYC(600),
    .EARLY_WINDOW_CYC(500), .RESET_PULSE_CYC(10), .CLEAR_CYC(3)) DUT (
    .mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .serial_in(mosi), .serial_out(so),
    .serial_out_oe(so_oe), .hard_clear_pin(hclr), .step_pulse(step),
    .rot_sense(rot), .status_events(ev), .reset_out_n(rst_out_n),
    .reset_out_oe(roe), .fault_n(fault), .fault_oe(foe),
    .step_out(step_out), .rot_sense_out(rso), .drivers_hiz(hiz),
    .clocks_run(crun),
    .ctrl_regs(cr));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // count host reset pulses
  always @(negedge rst_out_n) begin
    fires++;
  end
  // the host reset pin is driven exactly while its pulse is low
  always @(negedge mclk) begin
    if (reset_n) begin
      `CHK("reset drive", ~rst_out_n, roe)
    end
  end
  // compare each returned byte with the oldest note
  always @(posedge mclk) begin
    if (H.rx_q.size() > 0) begin
      got = H.rx_q.pop_front();
      eb = exp_q.pop_front();
      `CHK("returned byte", eb, got[7:0])
    end
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] dv,
                    input logic [7:0] old);
    exp_q.push_back(old);
    H.xfer({8'h00, OP_WRITE, a, dv}, 16, 1'b1);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    H.xfer({8'h00, OP_READ, a, 8'h00}, 16, 1'b1);
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // a hang costs one mismatch and ends the run
  initial begin
    repeat (40000) @(posedge mclk);
    fails++;
    conclude();
  end
  initial begin
    reset_n = 1'b0;
    hclr = 1'b0;
    step = 1'b0;
    rot = 1'b0;
    ev = '0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    repeat (6) @(negedge mclk);
    `CHK("ctrl reset", 32'h0000_0000, cr)
    `CHK("host reset idle", 1'b1, rst_out_n)
    `CHK("data out released", 1'b0, so_oe)
    done("reset");
    // write twice so the second returns the first value
    for (int i = 1; i <= 2; i++) begin
      r = rnd();
      d = r[7:0];
      rot = r[8];
      wr(i[4:0], d, 8'h00);
      wr(i[4:0], ~d, d);
      rd(i[4:0], ~d);
      `CHK("ctrl reg", ~d, cr[i])
      `CHK("rot sense", rot, rso)
    end
    done("readback");
    exp_c = cr;
    H.xfer({9'h000, OP_WRITE, 5'h01, 7'h2d}, 15, 1'b0);
    H.xfer({OP_WRITE, 5'h01, 8'h5a, 8'h5a}, 24, 1'b0);
    `CHK("bad length", exp_c, cr)
    H.xfer({8'h00, OP_WRITE, ADDR_SR0, 8'hff}, 16, 1'b0);
    `CHK("read-only write", exp_c, cr)
    done("discard");
    // latch an error while select is high, then read it away
    r = rnd();
    v = r[6:0] | 7'h01;
    ev[1] = v;
    repeat (4) @(negedge mclk);
    ev = '0;
    repeat (4) @(negedge mclk);
    `CHK("fault on", 1'b0, fault)
    `CHK("fault drive", 1'b1, foe)
    rd(5'h05, {^v, v});
    repeat (4) @(negedge mclk);
    `CHK("fault off", 1'b1, fault)
    `CHK("fault released", 1'b0, foe)
    // host fetches the status a second time
    rd(5'h05, 8'h00);
    done("status");
    // select 1 gives a 1200-cycle timeout; the early window is 500
    wr(ADDR_CRWD, 8'h88, 8'h00);
    wr(ADDR_CRWD, 8'h88, 8'h88);
    repeat (30) @(negedge mclk);
    `CHK("early rewrite", 1, fires)
    rd(ADDR_SR0, 8'hc0);
    wr(ADDR_CRWD, 8'h88, 8'h88);
    repeat (30) @(negedge mclk);
    `CHK("timely rewrite", 1, fires)
    repeat (1300) @(negedge mclk);
    `CHK("timeout", 2, fires)
    wr(ADDR_CRWD, 8'h00, 8'h88);
    repeat (1300) @(negedge mclk);
    `CHK("disabled", 2, fires)
    rd(ADDR_SR0, 8'h00);
    done("watchdog");
    H.xfer({8'h00, OP_WRITE, 5'h01, 8'h3c}, 16, 1'b0);
    hclr = 1'b1;
    repeat (10) @(negedge mclk);
    hclr = 1'b0;
    repeat (6) @(negedge mclk);
    `CHK("hard clear", 32'h0000_0000, cr)
    `CHK("no host reset", 2, fires)
    done("clear");
    wr(ADDR_CR2, 8'h40, 8'h00);
    step = 1'b1;
    rot = ~rot;
    repeat (8) @(negedge mclk);
    `CHK("sleep sense", ~rot, rso)
    `CHK("sleep hiz", 1'b1, hiz)
    `CHK("sleep step", 1'b0, step_out)
    `CHK("sleep clocks", 1'b0, crun)
    step = 1'b0;
    hclr = 1'b1;
    repeat (10) @(negedge mclk);
    hclr = 1'b0;
    repeat (6) @(negedge mclk);
    `CHK("clear in sleep", 8'h40, cr[3])
    wr(ADDR_CR2, 8'h80, 8'h40);
    // pump start-up wait before any step
    repeat (20) @(negedge mclk);
    `CHK("awake drivers", 1'b0, hiz)
    step = 1'b1;
    repeat (8) @(negedge mclk);
    `CHK("awake step", 1'b1, step_out)
    done("sleep");
    repeat (4) @(negedge mclk);
    conclude();
  end
endmodule
`default_nettype wire
